// *** hdl/boot_strap_pin_mux.sv ***
// boot strap pin multiplexer: routes thirteen shared pins per latched straps
// assumes straps on address pins held stable while rst_n is low

module boot_strap_pin_mux (
  input wire logic clk_sys,
  input wire logic rst_n,
  // strap pins, sampled through synchronisers
  input wire logic ecc_strap,
  input wire logic ac_link_strap,
  // shared check bits pins
  input wire logic [pin_mux_pkg::CHECK_WIDTH-1:0] check_bits_in,
  output pin_mux_pkg::check_drive_type check_bits_pin,
  // shared gpio 4..2 pins
  input wire logic [2:0] gpio_low_in,
  output pin_mux_pkg::low_gpio_drive_type gpio_low_pin,
  // dma request 2 and acknowledge 2 pins
  input wire logic dma_request_in,
  output logic dma_request_out,
  output logic dma_request_oe,
  output logic dma_acknowledge_out,
  // memory controller check bits side
  input wire logic [pin_mux_pkg::CHECK_WIDTH-1:0] ecc_out,
  input wire logic [pin_mux_pkg::CHECK_WIDTH-1:0] ecc_oe,
  output logic [pin_mux_pkg::CHECK_WIDTH-1:0] ecc_in,
  // gpio unit side (bits 15..8 and 4..2)
  input wire logic [pin_mux_pkg::CHECK_WIDTH-1:0] gpio_high_out,
  input wire logic [pin_mux_pkg::CHECK_WIDTH-1:0] gpio_high_oe,
  output logic [pin_mux_pkg::CHECK_WIDTH-1:0] gpio_high_in,
  input wire logic [2:0] gpio_low_out,
  input wire logic [2:0] gpio_low_oe,
  output logic [2:0] gpio_low_core_in,
  // ac link unit side
  input wire logic codec_reset_n,
  input wire logic codec_sync,
  input wire logic codec_sdout,
  output logic codec_sdin,
  output logic codec_bitclk,
  // dma channel 2 side
  input wire logic dma_ack_core,
  output logic dma_req_core,
  // power, clock generator reset, trace
  input wire logic halt_mode,
  input wire logic doze_mode,
  output logic low_power_state_out,
  input wire logic clock_gen_reset_n,
  output logic clock_gen_init,
  input wire logic [pin_mux_pkg::TRACE_WIDTH-1:0] trace_core,
  output logic [pin_mux_pkg::TRACE_WIDTH-1:0] trace_status,
  output logic ac_link_mode,
  output logic ecc_mode
);
  import pin_mux_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (CHECK_WIDTH + 5 != SHARED_PINS) begin : g_pin_count
    $error("shared pin count does not add up"); // see RULE1
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // first stage read only by the second
  logic [1:0] strap_meta;  // strap first stage
  logic [1:0] strap_sync;  // strap second stage
  logic [CHECK_WIDTH-1:0] check_meta;
  logic [CHECK_WIDTH-1:0] check_sync;
  logic [2:0] gpio_meta;
  logic [2:0] gpio_sync;
  logic dreq_meta;
  logic dreq_sync;
  logic cgr_meta;
  logic cgr_sync;

  // pin inputs pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
      check_meta <= '0;
      check_sync <= '0;
      gpio_meta <= 3'h0;
      gpio_sync <= 3'h0;
      dreq_meta <= 1'h0;
      dreq_sync <= 1'h0;
    end else begin
      strap_meta <= {ecc_strap, ac_link_strap};
      strap_sync <= strap_meta;
      check_meta <= check_bits_in;
      check_sync <= check_meta;
      gpio_meta <= gpio_low_in;
      gpio_sync <= gpio_meta;
      dreq_meta <= dma_request_in;
      dreq_sync <= dreq_meta;
    end
  end

  // clock gen reset synchronised on its own; system reset does not touch it
  always_ff @(posedge clk_sys) begin
    cgr_meta <= clock_gen_reset_n;
    cgr_sync <= cgr_meta;
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // straps captured once, a fixed count after release so the sync chain is full
  strap_type strap;         // latched configuration
  logic [1:0] settle;       // edges since release
  logic captured;           // capture done

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 2'h0;
      captured <= 1'h0;
      strap <= STRAP_RESET;
    end else if (!captured) begin
      if (settle == 2'(SYNC_STAGES)) begin
        strap <= strap_sync;   // see RULE8
        captured <= 1'h1;
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  // all outputs registered; until capture pins stay undriven for safety
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      check_bits_pin <= '0;
      ecc_in <= '0;
      gpio_high_in <= '0;
      ecc_mode <= 1'h0;
    end else begin
      ecc_mode <= captured & strap.ecc;
      if (captured && strap.ecc) begin
        check_bits_pin <= {ecc_out, ecc_oe};   // see RULE2
        ecc_in <= check_sync;
        gpio_high_in <= '0;
      end else if (captured) begin
        check_bits_pin <= {gpio_high_out, gpio_high_oe}; // see RULE2
        gpio_high_in <= check_sync;
        ecc_in <= '0;
      end else begin
        check_bits_pin <= '0;
        ecc_in <= '0;
        gpio_high_in <= '0;
      end
    end
  end

  // ac link versus dma 2 and low gpio
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_low_pin <= '0;
      dma_request_out <= 1'h0;
      dma_request_oe <= 1'h0;
      dma_acknowledge_out <= 1'h0;
      codec_sdin <= 1'h0;
      codec_bitclk <= 1'h0;
      gpio_low_core_in <= 3'h0;
      dma_req_core <= 1'h0;
      ac_link_mode <= 1'h0;
    end else begin
      ac_link_mode <= captured & strap.ac_link;
      if (captured && strap.ac_link) begin
        dma_request_out <= codec_reset_n;           // see RULE3
        dma_request_oe <= 1'h1;
        dma_acknowledge_out <= codec_sync;          // see RULE3
        gpio_low_pin.out <= 3'(codec_sdout) << GPIO_SDOUT;
        gpio_low_pin.oe <= 3'h1 << GPIO_SDOUT;     // only sdout driven
        codec_sdin <= gpio_sync[GPIO_SDIN];
        codec_bitclk <= gpio_sync[GPIO_BITCLK];
        gpio_low_core_in <= 3'h0;
        dma_req_core <= 1'h0;
      end else begin
        dma_request_out <= 1'h0;                    // see RULE4
        dma_request_oe <= 1'h0;
        dma_acknowledge_out <= captured & dma_ack_core;
        gpio_low_pin.out <= gpio_low_out;
        gpio_low_pin.oe <= captured ? gpio_low_oe : 3'h0; // see RULE4
        codec_sdin <= 1'h0;
        codec_bitclk <= 1'h0;
        gpio_low_core_in <= gpio_sync;
        dma_req_core <= dreq_sync;
      end
    end
  end

  // ----------------------------------------
  // power, clock gen reset, trace
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_power_state_out <= 1'h0;
      trace_status <= '0;
    end else begin
      low_power_state_out <= halt_mode | doze_mode; // see RULE5
      trace_status <= trace_core;                   // see RULE7
    end
  end

  // initialise pulse level, independent of rst_n
  always_ff @(posedge clk_sys) begin
    clock_gen_init <= ~cgr_sync; // see RULE6
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence release_s;
    $rose(captured);
  endsequence

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE8
    captured |=> $stable(strap)) else $error("strap changed after capture");
  strap_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE8
    release_s |-> strap == $past(strap_sync)) else $error("wrong strap captured");
  ecc_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    (captured && strap.ecc) |=> check_bits_pin.oe == $past(ecc_oe))
    else $error("check bits not routed to ecc");
  gpio_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
    (captured && !strap.ecc) |=> check_bits_pin.out == $past(gpio_high_out))
    else $error("check bits not routed to gpio");
  codec_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE3
    (captured && strap.ac_link) |=> dma_request_oe && dma_request_out == $past(codec_reset_n))
    else $error("codec reset not driven");
  dma_input_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE4
    !(captured && strap.ac_link) |=> !dma_request_oe) else $error("dma request driven");
  low_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE5
    rst_n && (halt_mode || doze_mode) |=> low_power_state_out) else $error("low power not shown");
  // the release edge itself still loads reset values, so it starts no check
  trace_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE7
    rst_n |=> trace_status == $past(trace_core)) else $error("trace status mismatch");
  cg_reset_a: assert property (@(posedge clk_sys) // see RULE6
    !clock_gen_reset_n [*3] |=> clock_gen_init) else $error("clock gen not initialised");
endmodule // boot_strap_pin_mux

// *** hdl/pin_mux_pkg.sv ***
// constants and carrier types for the boot strap pin multiplexer
// assumes a single 200 MHz system clock and straps stable during reset
//
// Functional notes
// RULE1: thirteen shared pins, two boot-selected functions
// RULE2: ecc strap picks check bits or gpio 15..8
// RULE3: ac link strap set: codec pins on shared
// RULE4: ac link strap clear: dma 2 and gpio
// RULE5: low power output high in halt or doze
// RULE6: clock gen reset initializes clock generator separately
// RULE7: nine-bit trace status with monitor mode out; the module has trace_status only, no monitor mode output
// RULE8: straps latched at reset release, held fixed
package pin_mux_pkg;
  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int CHECK_WIDTH = 8;          // shared check / upper gpio pins
  localparam int TRACE_WIDTH = 9;          // trace status bus
  localparam int SHARED_PINS = 13;         // total multiplexed pins
  localparam int SYNC_STAGES = 2;          // pin synchroniser depth
  localparam int GPIO_SDOUT = 2;           // index in gpio 4..2 group for sdout
  localparam int GPIO_SDIN = 1;            // index for sdin
  localparam int GPIO_BITCLK = 0;          // index for bitclk
  localparam logic [1:0] STRAP_RESET = 2'h0; // strap latch reset value

  // output and enable view of one group of two-way pins
  typedef struct packed {
    logic [CHECK_WIDTH-1:0] out;
    logic [CHECK_WIDTH-1:0] oe;
  } check_drive_type;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } low_gpio_drive_type;

  // latched boot configuration
  typedef struct packed {
    logic ecc;       // 1: memory check bits
    logic ac_link;   // 1: ac link mode
  } strap_type;
endpackage

// *** tb/board_model.sv ***
// board side of the pin mux: strap resistors and far-side drivers
// assumes the bench sets the straps as reset goes low and holds them through it
module board_model (
  input wire pin_mux_pkg::strap_type cfg,
  input wire logic [7:0] ext_check,
  input wire logic [2:0] ext_low,
  input wire logic ext_req,
  input wire pin_mux_pkg::check_drive_type check_bits_pin,
  input wire pin_mux_pkg::low_gpio_drive_type gpio_low_pin,
  input wire logic dma_request_out,
  input wire logic dma_request_oe,
  output logic ecc_strap,
  output logic ac_link_strap,
  output logic [7:0] check_bits_in,
  output logic [2:0] gpio_low_in,
  output logic dma_request_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  // ---------------------------------
  // strap resistors, fixed by the board
  // ---------------------------------
  assign ecc_strap = cfg.ecc;
  assign ac_link_strap = cfg.ac_link;
  // ---------------------------------
  // pin levels: device level where it drives, board level elsewhere
  // ---------------------------------
  // the board never fights a driven pin, so no contention is modelled
  assign check_bits_in = (check_bits_pin.out & check_bits_pin.oe)
    | (ext_check & ~check_bits_pin.oe);
  assign gpio_low_in = (gpio_low_pin.out & gpio_low_pin.oe) | (ext_low & ~gpio_low_pin.oe);
  assign dma_request_in = dma_request_oe ? dma_request_out : ext_req;
endmodule // board_model

// *** tb/boot_strap_pin_mux_bench.sv ***
// bench for the boot strap pin mux: each scenario drives and judges itself
// assumes board_model stands on the pin side
module boot_strap_pin_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  // ---------------------------------
  // stimulus and observed signals
  // ---------------------------------
  logic clk_sys = 1'b0, rst_n = 1'b0, ext_req = 1'b1, halt_mode = 1'b0, doze_mode = 1'b0;
  logic codec_reset_n = 1'b0, codec_sync = 1'b1, codec_sdout = 1'b1, dma_ack_core = 1'b0;
  logic clock_gen_reset_n = 1'b1;
  strap_type cfg = 2'h0;
  logic [7:0] ext_check = 8'h5A, ecc_out = 8'hA5, ecc_oe = 8'h3C;
  logic [7:0] gpio_high_out = 8'hC3, gpio_high_oe = 8'h0F;
  logic [2:0] ext_low = 3'h5, gpio_low_out = 3'h6, gpio_low_oe = 3'h1;
  logic [8:0] trace_core = 9'h000;
  check_drive_type check_bits_pin;
  low_gpio_drive_type gpio_low_pin;
  logic [7:0] check_bits_in, ecc_in, gpio_high_in;
  logic [2:0] gpio_low_in, gpio_low_core_in;
  logic [8:0] trace_status;
  logic ecc_strap, ac_link_strap, dma_request_in, dma_request_out, dma_request_oe;
  logic dma_acknowledge_out, codec_sdin, codec_bitclk, dma_req_core;
  logic low_power_state_out, clock_gen_init, ac_link_mode, ecc_mode;
  int n_fail = 0, total_checks = 0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  boot_strap_pin_mux boot_strap_pin_mux_inst (.clk_sys, .rst_n, .ecc_strap, .ac_link_strap,
    .check_bits_in, .check_bits_pin, .gpio_low_in, .gpio_low_pin, .dma_request_in,
    .dma_request_out, .dma_request_oe, .dma_acknowledge_out, .ecc_out, .ecc_oe, .ecc_in,
    .gpio_high_out, .gpio_high_oe, .gpio_high_in, .gpio_low_out, .gpio_low_oe,
    .gpio_low_core_in, .codec_reset_n, .codec_sync, .codec_sdout, .codec_sdin,
    .codec_bitclk, .dma_ack_core, .dma_req_core, .halt_mode, .doze_mode,
    .low_power_state_out, .clock_gen_reset_n, .clock_gen_init, .trace_core,
    .trace_status, .ac_link_mode, .ecc_mode);
  board_model board_model_inst (.cfg, .ext_check, .ext_low, .ext_req,
    .check_bits_pin, .gpio_low_pin, .dma_request_out, .dma_request_oe, .ecc_strap,
    .ac_link_strap, .check_bits_in, .gpio_low_in, .dma_request_in);
  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // straps set first and left alone through the 5-cycle reset
  task automatic boot(input strap_type s);
    @(posedge clk_sys);
    cfg <= s;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    // capture takes 3 edges, then a pin needs 4 more to be driven and reach the core side
    repeat (8) @(posedge clk_sys);
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  // second pass inverts ecc_out, ext_check, ext_low and codec_sdout and sets the codec, dma ack and ext_req levels to 4'hA
  task automatic pin_routes(input logic e, input logic a);
    boot({e, a});
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        {codec_reset_n, codec_sync, dma_ack_core, ext_req} <= 4'hA;
        {ecc_out, ext_check, ext_low, codec_sdout} <= ~{ecc_out, ext_check, ext_low, codec_sdout};
        repeat (5) @(posedge clk_sys);
      end
      #1;
      check({ecc_mode, ac_link_mode}, {e, a});
      check(check_bits_pin, e ? {ecc_out, ecc_oe} : {gpio_high_out, gpio_high_oe});
      check(e ? ecc_in : gpio_high_in, check_bits_in);
      check(check_bits_in & ~check_bits_pin.oe,
        ext_check & ~(e ? ecc_oe : gpio_high_oe));
      if (a) begin
        check({dma_request_oe, dma_request_out, dma_acknowledge_out},
          {1'b1, codec_reset_n, codec_sync});
        check({gpio_low_pin.out[2], gpio_low_pin.oe}, {codec_sdout, 3'h4});
        check({codec_sdin, codec_bitclk}, ext_low[1:0]);
      end else begin
        check({dma_request_oe, dma_req_core, dma_acknowledge_out},
          {1'b0, ext_req, dma_ack_core});
        check(gpio_low_pin, {gpio_low_out, gpio_low_oe});
        check(gpio_low_core_in,
          (gpio_low_out & gpio_low_oe) | (ext_low & ~gpio_low_oe));
      end
      @(posedge clk_sys);
    end
  endtask
  // strap moves after capture must not reach the mode
  task automatic strap_lock();
    @(posedge clk_sys);
    cfg <= ~cfg;
    repeat (6) @(posedge clk_sys);
    #1;
    // braces keep the inversion at two bits, not sixteen
    check({ecc_mode, ac_link_mode}, {~cfg});
  endtask
  // all four halt / doze combinations, each with one of two trace words
  task automatic power_trace();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      {halt_mode, doze_mode} <= k[1:0];
      trace_core <= k[0] ? 9'h1A5 : 9'h05A;
      repeat (2) @(posedge clk_sys);
      #1;
      check(low_power_state_out, k != 0);
      check(trace_status, k[0] ? 9'h1A5 : 9'h05A);
    end
  endtask
  // clock generator reset and system reset must not touch each other
  task automatic cg_reset();
    @(posedge clk_sys);
    clock_gen_reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check({clock_gen_init, ecc_mode, ac_link_mode}, {1'b1, ~cfg});
    @(posedge clk_sys);
    clock_gen_reset_n <= 1'b1;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check({clock_gen_init, ecc_mode, check_bits_pin.oe, dma_request_oe}, 16'h0);
  endtask
  initial begin
    for (int k = 0; k < 4; k++) pin_routes(k[1], k[0]);
    strap_lock();
    power_trace();
    cg_reset();
    close_out();
  end
endmodule // boot_strap_pin_mux_bench
